// *** wdts_consts.svh ***
/*
 * Constants of the strap-selected watchdog: register offsets, field
 * positions, reset values and timing counts.
 * Assumes a 40 MHz core clock; all cycle counts are derived from that rate.
 */
`ifndef WDTS_CONSTS_SVH
`define WDTS_CONSTS_SVH

`define WDTS_CLK_HZ 40000000
`define WDTS_CYC_PER_MS (`WDTS_CLK_HZ / 1000)
`define WDTS_CYC_PER_US (`WDTS_CLK_HZ / 1000000)

// Factory timeouts, open strap
`define WDTS_TO_OPEN_MIN_MS 1360
`define WDTS_TO_OPEN_MS 1600
`define WDTS_TO_OPEN_MAX_MS 1840
`define WDTS_TO_OPEN_CYC (`WDTS_TO_OPEN_MS * `WDTS_CYC_PER_MS)
// Factory timeouts, pulled-up strap
`define WDTS_TO_PULLUP_MIN_MS 170
`define WDTS_TO_PULLUP_MS 200
`define WDTS_TO_PULLUP_MAX_MS 230
`define WDTS_TO_PULLUP_CYC (`WDTS_TO_PULLUP_MS * `WDTS_CYC_PER_MS)
// Capacitor mode: fixed offset plus a number of threshold ramps
`define WDTS_CAP_OFFSET_MS 55
`define WDTS_CAP_OFFSET_CYC (`WDTS_CAP_OFFSET_MS * `WDTS_CYC_PER_MS)
`define WDTS_CAP_RAMPS 24
// Re-enable setup window
`define WDTS_SETUP_US 150
`define WDTS_SETUP_CYC (`WDTS_SETUP_US * `WDTS_CYC_PER_US)
// Strap probe timing
`define WDTS_DISCH_US 5
`define WDTS_DISCH_CYC (`WDTS_DISCH_US * `WDTS_CYC_PER_US)
`define WDTS_SETTLE_US 2
`define WDTS_SETTLE_CYC (`WDTS_SETTLE_US * `WDTS_CYC_PER_US)
`define WDTS_PROBE_US 20
`define WDTS_PROBE_CYC (`WDTS_PROBE_US * `WDTS_CYC_PER_US)

// Register byte offsets
`define WDTS_REG_CTRL 5'h00
`define WDTS_REG_STATE 5'h04
`define WDTS_REG_IRQ_STAT 5'h08
`define WDTS_REG_IRQ_CLR 5'h0c
`define WDTS_REG_IRQ_EN 5'h10
`define WDTS_REG_RAMP 5'h14

// Field positions
`define WDTS_CTRL_EN_BIT 0
`define WDTS_IRQ_FAULT_BIT 0
`define WDTS_IRQ_RECOVER_BIT 1
`define WDTS_IRQ_CFG_BIT 2
`define WDTS_STATE_WD_LSB 0
`define WDTS_STATE_MODE_LSB 4
`define WDTS_STATE_CFG_BIT 6
`define WDTS_STATE_FAULT_BIT 7
`define WDTS_STATE_DISPIN_BIT 8
`define WDTS_STATE_FPIN_BIT 9

// Reset values
`define WDTS_CTRL_EN_RST 1'h1
`define WDTS_IRQ_EN_RST 3'h0

`endif

// *** wdts_pkg.sv ***
/*
 * Types of the strap-selected watchdog: modes, state encodings and the
 * packed state of each module.
 * Assumes wdts_consts.svh for numeric values.
 */
package wdts_pkg;

    typedef enum logic [1:0] {
        WDTS_MODE_OPEN = 2'h0,
        WDTS_MODE_PULLUP = 2'h1,
        WDTS_MODE_CAP = 2'h2
    } wdts_mode_e;

    typedef struct packed {
        logic done;
        wdts_mode_e mode;
    } wdts_cfg_s;

    typedef enum logic [3:0] {
        PR_DISCH = 4'h1,
        PR_SETTLE = 4'h2,
        PR_PROBE = 4'h4,
        PR_DONE = 4'h8
    } wdts_probe_e;

    typedef enum logic [3:0] {
        WD_OFF = 4'h1,
        WD_SETUP = 4'h2,
        WD_RUN = 4'h4,
        WD_FAULT = 4'h8
    } wdts_wd_e;

    typedef enum logic [2:0] {
        CP_OFFSET = 3'h1,
        CP_DISCH = 3'h2,
        CP_CHARGE = 3'h4
    } wdts_cph_e;

    typedef struct packed {
        logic prev;
        logic fall;
    } wdts_edge_s;

    typedef struct packed {
        wdts_probe_e st;
        logic [15:0] cnt;
        logic oe;
        logic chg;
        wdts_cfg_s cfg;
    } wdts_probe_s;

    typedef struct packed {
        logic wait_req;
        logic [31:0] rdata;
        logic ctrl_en;
        logic [2:0] irq_en;
        logic [2:0] irq_stat;
        logic irq;
        logic cfg_seen;
        wdts_wd_e wd;
        wdts_cph_e cph;
        logic [31:0] cnt;
        logic [7:0] ramps;
        logic [31:0] ramp_last;
        logic fault;
        logic pin_oe;
        logic charge;
    } wdts_top_s;

endpackage : wdts_pkg

// *** wdts_fall_det.sv ***
/*
 * Falling-edge detector giving a one-cycle registered pulse.
 * Assumes the input is synchronous to core_clk.
 */
`timescale 1ns/1ps
`default_nettype none

module wdts_fall_det (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic sig,
    output logic fall
);

    wdts_pkg::wdts_edge_s q;
    wdts_pkg::wdts_edge_s d;

    always_comb
    begin
        d = q;
        d.prev = sig;
        d.fall = q.prev & ~sig;
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
        end
        else
        begin
            q <= d;
        end
    end

    assign fall = q.fall;

endmodule : wdts_fall_det

`default_nettype wire

// *** wdts_cfg_probe.sv ***
/*
 * Strap evaluation of the timeout configuration pin after reset:
 * discharge, check for a pull-up, then charge briefly to tell an open
 * pin from a capacitor.
 * Assumes pin_i is the threshold comparator of the pin, synchronous.
 */
`timescale 1ns/1ps
`default_nettype none
`include "wdts_consts.svh"

module wdts_cfg_probe #(
    parameter int unsigned DISCH_CYC = `WDTS_DISCH_CYC,
    parameter int unsigned SETTLE_CYC = `WDTS_SETTLE_CYC,
    parameter int unsigned PROBE_CYC = `WDTS_PROBE_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic pin_i,
    output logic pin_oe,
    output logic charge_en,
    output wdts_pkg::wdts_cfg_s cfg
);

    localparam logic [15:0] DISCH_END = 16'(DISCH_CYC - 1);
    localparam logic [15:0] SETTLE_END = 16'(SETTLE_CYC - 1);
    localparam logic [15:0] PROBE_END = 16'(PROBE_CYC - 1);

    wdts_pkg::wdts_probe_s q;
    wdts_pkg::wdts_probe_s d;

    always_comb
    begin
        d = q;
        d.cnt = q.cnt + 16'h0001;
        case (q.st)
            wdts_pkg::PR_DISCH:
            begin
                d.oe = 1'b1;
                if (q.cnt >= DISCH_END)
                begin
                    d.st = wdts_pkg::PR_SETTLE;
                    d.cnt = '0;
                    d.oe = 1'b0;
                end
            end
            wdts_pkg::PR_SETTLE:
            begin
                if (q.cnt >= SETTLE_END)
                begin
                    d.cnt = '0;
                    if (pin_i)
                    begin
                        d.cfg.mode = wdts_pkg::WDTS_MODE_PULLUP;
                        d.cfg.done = 1'b1;
                        d.st = wdts_pkg::PR_DONE;
                    end
                    else
                    begin
                        d.chg = 1'b1;
                        d.st = wdts_pkg::PR_PROBE;
                    end
                end
            end
            wdts_pkg::PR_PROBE:
            begin
                if (pin_i || q.cnt >= PROBE_END)
                begin
                    d.cfg.mode = pin_i ? wdts_pkg::WDTS_MODE_OPEN
                                       : wdts_pkg::WDTS_MODE_CAP;
                    d.cfg.done = 1'b1;
                    d.chg = 1'b0;
                    d.oe = 1'b1;
                    d.st = wdts_pkg::PR_DONE;
                end
            end
            wdts_pkg::PR_DONE:
            begin
                d.cnt = q.cnt;
            end
            default:
            begin
                d.st = wdts_pkg::PR_DISCH;
            end
        endcase
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.st <= wdts_pkg::PR_DISCH;
            q.oe <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign pin_oe = q.oe;
    assign charge_en = q.chg;
    assign cfg = q.cfg;

endmodule : wdts_cfg_probe

`default_nettype wire

// *** wdts_top.sv ***
/*
 * Watchdog with strap-selected timeout: factory long, factory short or
 * capacitor ramp; Avalon-MM register slave and a level interrupt.
 * Assumes all pins synchronous to core_clk; the timeout pin has an
 * external current source switched by cap_charge_en and a threshold
 * comparator seen on timeout_config_pin_i.
 */
// What this block does
// - Open or pulled-up strap selects factory timeout
// - Capacitor to ground sets adjustable timeout
// - Open strap, enabled: 1600 ms typical timeout
// - Pulled-up strap, enabled: 200 ms typical timeout
// - Capacitor charges to threshold, ending one interval
// - Capacitor timeout equals 77.4 ms/nF plus 55
// - Capacitor timeout within 0.905 to 1.095 typical
// - Capacitors from 100 pF to 1 uF supported
// - Fault asserts when kick interval exceeds timeout
// - Fault clears when timely kicks resume
// - Disable pin low ignores kicks, disables watchdog
// - Only falling kick edges count
`timescale 1ns/1ps
`default_nettype none
`include "wdts_consts.svh"

module wdts_top #(
    parameter int unsigned TO_OPEN_CYC = `WDTS_TO_OPEN_CYC,
    parameter int unsigned TO_PULLUP_CYC = `WDTS_TO_PULLUP_CYC,
    parameter int unsigned CAP_OFFSET_CYC = `WDTS_CAP_OFFSET_CYC,
    parameter int unsigned CAP_RAMPS = `WDTS_CAP_RAMPS,
    parameter int unsigned SETUP_CYC = `WDTS_SETUP_CYC,
    parameter int unsigned DISCH_CYC = `WDTS_DISCH_CYC
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic [4:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic kick_input,
    input wire logic watchdog_disable_pin,
    input wire logic timeout_config_pin_i,
    output logic timeout_config_pin_o,
    output logic timeout_config_pin_oe,
    output logic cap_charge_en,
    input wire logic fault_output_n_i,
    output logic fault_output_n_o,
    output logic fault_output_n_oe,
    output logic irq
);

    localparam logic [31:0] OPEN_END = 32'(TO_OPEN_CYC - 1);
    localparam logic [31:0] PULLUP_END = 32'(TO_PULLUP_CYC - 1);
    localparam logic [31:0] OFFSET_END = 32'(CAP_OFFSET_CYC - 1);
    localparam logic [31:0] SETUP_END = 32'(SETUP_CYC - 1);
    localparam logic [31:0] DISCH_END = 32'(DISCH_CYC - 1);
    localparam logic [7:0] RAMPS_END = 8'(CAP_RAMPS - 1);

    wdts_pkg::wdts_top_s q;
    wdts_pkg::wdts_top_s d;
    wdts_pkg::wdts_cfg_s cfg;
    logic kick_fall;
    logic probe_oe;
    logic probe_chg;

    logic req;
    logic take;
    logic en;
    logic expire;
    logic [2:0] ev;
    logic [2:0] clr;
    logic [31:0] rd_mux;
    logic [31:0] lim;

    wdts_fall_det u_kick (
        .core_clk(core_clk),
        .srst(srst),
        .sig(kick_input),
        .fall(kick_fall)
    );

    wdts_cfg_probe #(
        .DISCH_CYC(`WDTS_DISCH_CYC),
        .SETTLE_CYC(`WDTS_SETTLE_CYC),
        .PROBE_CYC(`WDTS_PROBE_CYC)
    ) u_probe (
        .core_clk(core_clk),
        .srst(srst),
        .pin_i(timeout_config_pin_i),
        .pin_oe(probe_oe),
        .charge_en(probe_chg),
        .cfg(cfg)
    );

    // Read data selection
    always_comb
    begin
        rd_mux = '0;
        case (avs_address)
            `WDTS_REG_CTRL:
            begin
                rd_mux[`WDTS_CTRL_EN_BIT] = q.ctrl_en;
            end
            `WDTS_REG_STATE:
            begin
                rd_mux[`WDTS_STATE_WD_LSB +: 4] = q.wd;
                rd_mux[`WDTS_STATE_MODE_LSB +: 2] = cfg.mode;
                rd_mux[`WDTS_STATE_CFG_BIT] = cfg.done;
                rd_mux[`WDTS_STATE_FAULT_BIT] = q.fault;
                rd_mux[`WDTS_STATE_DISPIN_BIT] = watchdog_disable_pin;
                rd_mux[`WDTS_STATE_FPIN_BIT] = fault_output_n_i;
            end
            `WDTS_REG_IRQ_STAT:
            begin
                rd_mux[2:0] = q.irq_stat;
            end
            `WDTS_REG_IRQ_EN:
            begin
                rd_mux[2:0] = q.irq_en;
            end
            `WDTS_REG_RAMP:
            begin
                rd_mux = q.ramp_last;
            end
            default:
            begin
                rd_mux = '0;
            end
        endcase
    end

    // Factory timeout limit by strap
    always_comb
    begin
        if (cfg.mode == wdts_pkg::WDTS_MODE_PULLUP)
        begin
            lim = PULLUP_END;
        end
        else
        begin
            lim = OPEN_END;
        end
    end

    always_comb
    begin
        d = q;
        ev = '0;
        clr = '0;
        expire = 1'b0;

        // Bus slave: one wait cycle, answer on the next edge
        req = avs_read | avs_write;
        take = req & ~q.wait_req;
        d.wait_req = ~(req & q.wait_req);
        if (req && q.wait_req)
        begin
            d.rdata = rd_mux;
        end
        if (avs_write && take)
        begin
            case (avs_address)
                `WDTS_REG_CTRL:
                begin
                    d.ctrl_en = avs_writedata[`WDTS_CTRL_EN_BIT];
                end
                `WDTS_REG_IRQ_CLR:
                begin
                    clr = avs_writedata[2:0];
                end
                `WDTS_REG_IRQ_EN:
                begin
                    d.irq_en = avs_writedata[2:0];
                end
                default:
                begin
                    clr = '0;
                end
            endcase
        end

        // Strap evaluation finished
        d.cfg_seen = cfg.done;
        ev[`WDTS_IRQ_CFG_BIT] = cfg.done & ~q.cfg_seen;

        en = watchdog_disable_pin & q.ctrl_en & cfg.done;
        d.cnt = q.cnt + 32'h0000_0001;

        case (q.wd)
            wdts_pkg::WD_OFF:
            begin
                d.cnt = '0;
                d.fault = 1'b0;
                d.pin_oe = 1'b0;
                d.charge = 1'b0;
                if (en)
                begin
                    d.wd = wdts_pkg::WD_SETUP;
                end
            end
            wdts_pkg::WD_SETUP:
            begin
                // Kicks ignored while the enable setup runs
                if (q.cnt >= SETUP_END)
                begin
                    d.wd = wdts_pkg::WD_RUN;
                    d.cnt = '0;
                    d.cph = wdts_pkg::CP_OFFSET;
                    d.ramps = '0;
                end
            end
            wdts_pkg::WD_RUN:
            begin
                if (kick_fall)
                begin
                    d.cnt = '0;
                    d.cph = wdts_pkg::CP_OFFSET;
                    d.ramps = '0;
                    d.charge = 1'b0;
                    d.pin_oe = (cfg.mode == wdts_pkg::WDTS_MODE_CAP);
                end
                else if (cfg.mode != wdts_pkg::WDTS_MODE_CAP)
                begin
                    d.pin_oe = 1'b0;
                    d.charge = 1'b0;
                    if (q.cnt >= lim)
                    begin
                        expire = 1'b1;
                    end
                end
                else
                begin
                    case (q.cph)
                        wdts_pkg::CP_OFFSET:
                        begin
                            d.pin_oe = 1'b1;
                            d.charge = 1'b0;
                            if (q.cnt >= OFFSET_END)
                            begin
                                d.cph = wdts_pkg::CP_CHARGE;
                                d.cnt = '0;
                                d.pin_oe = 1'b0;
                                d.charge = 1'b1;
                            end
                        end
                        wdts_pkg::CP_CHARGE:
                        begin
                            if (timeout_config_pin_i)
                            begin
                                d.ramp_last = q.cnt;
                                d.ramps = q.ramps + 8'h01;
                                d.charge = 1'b0;
                                d.pin_oe = 1'b1;
                                d.cnt = '0;
                                d.cph = wdts_pkg::CP_DISCH;
                                if (q.ramps >= RAMPS_END)
                                begin
                                    expire = 1'b1;
                                end
                            end
                        end
                        wdts_pkg::CP_DISCH:
                        begin
                            d.pin_oe = 1'b1;
                            if (q.cnt >= DISCH_END)
                            begin
                                d.cph = wdts_pkg::CP_CHARGE;
                                d.cnt = '0;
                                d.pin_oe = 1'b0;
                                d.charge = 1'b1;
                            end
                        end
                        default:
                        begin
                            d.cph = wdts_pkg::CP_OFFSET;
                        end
                    endcase
                end
                if (expire)
                begin
                    d.wd = wdts_pkg::WD_FAULT;
                    d.fault = 1'b1;
                    d.cnt = '0;
                    d.charge = 1'b0;
                    d.pin_oe = (cfg.mode == wdts_pkg::WDTS_MODE_CAP);
                    ev[`WDTS_IRQ_FAULT_BIT] = 1'b1;
                end
            end
            wdts_pkg::WD_FAULT:
            begin
                d.cnt = '0;
                if (kick_fall)
                begin
                    d.fault = 1'b0;
                    d.wd = wdts_pkg::WD_RUN;
                    d.cph = wdts_pkg::CP_OFFSET;
                    d.ramps = '0;
                    ev[`WDTS_IRQ_RECOVER_BIT] = 1'b1;
                end
            end
            default:
            begin
                d.wd = wdts_pkg::WD_OFF;
            end
        endcase

        // Disable clears state, fault, count and pin drive, kicks included; events still latch
        if (!en)
        begin
            d.wd = wdts_pkg::WD_OFF;
            d.fault = 1'b0;
            d.cnt = '0;
            d.charge = 1'b0;
            d.pin_oe = 1'b0;
        end

        // Probe owns the pin until the strap is known
        if (!cfg.done)
        begin
            d.pin_oe = probe_oe;
            d.charge = probe_chg;
        end

        // Sticky status: a new event wins over a clear
        d.irq_stat = (q.irq_stat & ~clr) | ev;
        d.irq = |(d.irq_stat & d.irq_en);
    end

    always_ff @(posedge core_clk)
    begin
        if (srst)
        begin
            q <= '0;
            q.wait_req <= 1'b1;
            q.ctrl_en <= `WDTS_CTRL_EN_RST;
            q.irq_en <= `WDTS_IRQ_EN_RST;
            q.wd <= wdts_pkg::WD_OFF;
            q.cph <= wdts_pkg::CP_OFFSET;
            q.pin_oe <= 1'b1;
        end
        else
        begin
            q <= d;
        end
    end

    assign avs_readdata = q.rdata;
    assign avs_waitrequest = q.wait_req;
    assign timeout_config_pin_o = ~q.pin_oe;
    assign timeout_config_pin_oe = q.pin_oe;
    assign cap_charge_en = q.charge;
    assign fault_output_n_o = ~q.fault;
    assign fault_output_n_oe = q.fault;
    assign irq = q.irq;

endmodule : wdts_top

`default_nettype wire

// *** wdts_props.sv ***
/* Checker of bus timing and watchdog pins of wdts_top.
   Bound in tb; sees only the ports of wdts_top. */
`timescale 1ns/1ps
`default_nettype none
module wdts_props #(
    parameter int unsigned TO_PULLUP_CYC = 100,
    parameter int unsigned CAP_OFFSET_CYC = 20
) (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic avs_waitrequest,
    input wire logic kick_input,
    input wire logic watchdog_disable_pin,
    input wire logic timeout_config_pin_oe,
    input wire logic fault_output_n_o,
    input wire logic fault_output_n_oe,
    input wire logic irq
);
    localparam int unsigned MIN_LIM = (TO_PULLUP_CYC < CAP_OFFSET_CYC) ?
        TO_PULLUP_CYC : CAP_OFFSET_CYC;
    logic [31:0] quiet_q;
    default clocking @(posedge core_clk); endclocking
    default disable iff (srst);
    // Cycles since the last falling kick edge or disable
    always_ff @(posedge core_clk)
    begin
        if (srst || !watchdog_disable_pin || $fell(kick_input))
            quiet_q <= 32'h0;
        else if (quiet_q != 32'hffffffff)
            quiet_q <= quiet_q + 32'h1;
    end
    a_fault_pin_pair: assert property (
        fault_output_n_o == !fault_output_n_oe)
        else $error("fault pin level and drive disagree");
    a_wait_one: assert property (
        (avs_read || avs_write) && avs_waitrequest |=> !avs_waitrequest)
        else $error("bus answer not after one wait cycle");
    a_wait_short: assert property (!avs_waitrequest |=> avs_waitrequest)
        else $error("waitrequest low for more than one cycle");
    a_wait_idle: assert property (
        !avs_read && !avs_write |=> avs_waitrequest)
        else $error("bus answer without a request");
    a_off_no_fault: assert property (
        (!watchdog_disable_pin) [*3] |-> !fault_output_n_oe)
        else $error("fault driven while watchdog disabled");
    a_kick_clears: assert property (
        $fell(kick_input) && fault_output_n_oe && watchdog_disable_pin
        |-> ##[1:3] !fault_output_n_oe)
        else $error("fault not cleared by kick");
    a_fault_quiet: assert property (
        $rose(fault_output_n_oe) |-> quiet_q + 32'h4 >= MIN_LIM)
        else $error("fault raised too soon after kick");
    a_reset_state: assert property ($fell(srst) |-> !fault_output_n_oe &&
        !irq && timeout_config_pin_oe && avs_waitrequest)
        else $error("outputs wrong after reset");
endmodule : wdts_props
`default_nettype wire

// *** wdts_mcu.sv ***
/* Processor model that toggles the kick pin every half+1 cycles.
   Assumes run and half are driven synchronously to core_clk. */
`timescale 1ns/1ps
`default_nettype none
module wdts_mcu (
    input wire logic core_clk,
    input wire logic srst,
    input wire logic run,
    input wire logic [7:0] half,
    output logic kick
);
    logic [7:0] cnt_q;
    always_ff @(posedge core_clk)
    begin
        if (srst)
            kick <= 1'b1;
        if (srst || !run)
            cnt_q <= 8'h00;
        else if (cnt_q >= half)
        begin
            cnt_q <= 8'h00;
            kick <= !kick;
        end
        else
            cnt_q <= cnt_q + 8'h01;
    end
endmodule : wdts_mcu
`default_nettype wire

// *** tb.sv ***
/* Self-checking bench of wdts_top for all three strap modes.
   Assumes wdts_consts.svh, wdts_pkg and the design compiled first. */
`timescale 1ns/1ps
`default_nettype none
`include "wdts_consts.svh"
module tb;
    localparam int unsigned TO_OPEN = 200;
    localparam int unsigned TO_PULL = 100;
    localparam int unsigned CAP_OFF = 20;
    localparam int unsigned CAP_N = 2;
    localparam int unsigned DISCH = 4;
    localparam int unsigned CAP_THR = 900;
    logic core_clk, srst, rd, wr, wait_req, kick, wd_on, cfg_i, cfg_oe;
    logic chg, fault_o, fault_oe, irq, run, kick_d;
    logic [4:0] addr;
    logic [31:0] wdata, rdata, q;
    logic [7:0] half;
    logic [1:0] strap;
    logic [11:0] level;
    int since, miscompares, n_compared;
    integer seed = 32'hdc364ef5;
    wdts_top #(.TO_OPEN_CYC(TO_OPEN), .TO_PULLUP_CYC(TO_PULL),
        .CAP_OFFSET_CYC(CAP_OFF), .CAP_RAMPS(CAP_N), .SETUP_CYC(10),
        .DISCH_CYC(DISCH)) dut (.core_clk(core_clk), .srst(srst),
        .avs_address(addr), .avs_read(rd), .avs_write(wr),
        .avs_writedata(wdata), .avs_readdata(rdata),
        .avs_waitrequest(wait_req), .kick_input(kick),
        .watchdog_disable_pin(wd_on), .timeout_config_pin_i(cfg_i),
        .timeout_config_pin_o(), .timeout_config_pin_oe(cfg_oe),
        .cap_charge_en(chg), .fault_output_n_i(!fault_oe),
        .fault_output_n_o(fault_o), .fault_output_n_oe(fault_oe),
        .irq(irq));
    wdts_mcu u_mcu (.core_clk(core_clk), .srst(srst), .run(run),
        .half(half), .kick(kick));
    always #12.5 core_clk = !core_clk;
    // Strap pin: pull-up, or a charge level that the current source raises
    always @(posedge core_clk)
    begin
        kick_d <= kick;
        since <= (kick_d && !kick) ? 0 : since + 1;
        level <= cfg_oe ? 12'h000 : level + 12'(chg && level != 12'hfff);
    end
    assign cfg_i = (strap == 2'h1) ? !cfg_oe :
        (level >= ((strap == 2'h0) ? 12'h00a : 12'h384));
    function automatic int lim(input logic [1:0] m);
        if (m == 2'h0)
            return TO_OPEN;
        if (m == 2'h1)
            return TO_PULL;
        return CAP_OFF + CAP_N * (CAP_THR + DISCH);
    endfunction : lim
    task automatic end_of_test();
        if (miscompares == 0 && n_compared > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask : end_of_test
    task automatic check(input string nm, input logic [31:0] seen, exp);
        n_compared++;
        if (seen !== exp)
        begin
            miscompares++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    task automatic bus(input logic w, input logic [4:0] a, input int d);
        int i;
        addr <= a;
        wr <= w;
        rd <= !w;
        wdata <= d;
        i = 0;
        @(posedge core_clk);
        while (wait_req !== 1'b0 && i < 50)
        begin
            @(posedge core_clk);
            i++;
        end
        check("bus wait", i >= 50, 0);
        if (i >= 50)
            end_of_test();
        q = rdata;
        rd <= 1'b0;
        wr <= 1'b0;
        @(posedge core_clk);
    endtask : bus
    task automatic wait_fault(input logic v, input int bound);
        int i;
        i = 0;
        while (fault_oe !== v && i < bound)
        begin
            @(posedge core_clk);
            i++;
        end
        check("fault wait", i >= bound, 0);
        if (i >= bound)
            end_of_test();
    endtask : wait_fault
    task automatic hold(input int n);
        int bad;
        bad = 0;
        repeat (n)
        begin
            @(posedge core_clk);
            bad += int'(fault_oe !== 1'b0);
        end
        check("fault held", bad, 0);
    endtask : hold
    task automatic run_mode(input logic [1:0] m);
        int i;
        strap <= m;
        srst <= 1'b1;
        run <= 1'b1;
        half <= 8'(10 + {$random(seed)} % 25);
        repeat (10) @(posedge core_clk);
        srst <= 1'b0;
        @(posedge core_clk);
        i = 0;
        q = '0;
        while (q[6] !== 1'b1 && i < 500)
        begin
            bus(1'b0, `WDTS_REG_STATE, 0);
            i++;
        end
        check("mode", q[6:4], {1'b1, m});
        if (i >= 500)
            end_of_test();
        bus(1'b0, `WDTS_REG_IRQ_STAT, 0);
        check("strap event", q, 32'h4);
        bus(1'b0, `WDTS_REG_IRQ_EN, 0);
        check("irq enable reset", q, 32'h0);
        bus(1'b0, `WDTS_REG_CTRL, 0);
        check("ctrl reset", q, 32'h1);
        bus(1'b1, 5'h1c, -1);
        bus(1'b0, 5'h1c, 0);
        check("unmapped", q, 32'h0);
        hold(3 * lim(m));
        run <= 1'b0;
        wait_fault(1'b1, 4000);
        check("timeout", since >= lim(m) - 8 && since <= lim(m) + 8,
            1);
        check("irq masked", irq, 1'b0);
        bus(1'b0, `WDTS_REG_IRQ_STAT, 0);
        check("fault event", q[0], 1'b1);
        bus(1'b1, `WDTS_REG_IRQ_EN, 3);
        @(posedge core_clk);
        check("irq raised", irq, 1'b1);
        if (m == 2'h0)
        begin
            wd_on <= 1'b0;
            repeat (4) @(posedge core_clk);
            hold(3 * TO_OPEN);
            bus(1'b0, `WDTS_REG_STATE, 0);
            check("off state", q[3:0], 4'h1);
            wd_on <= 1'b1;
            bus(1'b1, `WDTS_REG_CTRL, 0);
            bus(1'b0, `WDTS_REG_STATE, 0);
            check("ctrl off", q[3:0], 4'h1);
            bus(1'b1, `WDTS_REG_CTRL, 1);
            wait_fault(1'b1, 4000);
        end
        run <= 1'b1;
        wait_fault(1'b0, 200);
        bus(1'b0, `WDTS_REG_IRQ_STAT, 0);
        check("recover event", q[1:0], 2'h3);
        bus(1'b1, `WDTS_REG_IRQ_CLR, 7);
        @(posedge core_clk);
        check("irq cleared", irq, 1'b0);
        bus(1'b0, `WDTS_REG_IRQ_STAT, 0);
        check("status cleared", q, 32'h0);
        if (m == 2'h2)
        begin
            bus(1'b0, `WDTS_REG_RAMP, 0);
            check("ramp", q + 4 >= CAP_THR && q <= CAP_THR + 4, 1);
        end
    endtask : run_mode
    initial
    begin
        core_clk = 1'b0;
        srst <= 1'b1;
        addr <= 5'h00;
        rd <= 1'b0;
        wr <= 1'b0;
        wdata <= 32'h0;
        wd_on <= 1'b1;
        run <= 1'b0;
        half <= 8'h10;
        strap <= 2'h0;
        miscompares = 0;
        n_compared = 0;
        @(posedge core_clk);
        for (int m = 0; m < 3; m++)
            run_mode(2'(m));
        end_of_test();
    end
endmodule : tb
bind wdts_top wdts_props #(.TO_PULLUP_CYC(TO_PULLUP_CYC),
    .CAP_OFFSET_CYC(CAP_OFFSET_CYC)) u_props (.core_clk(core_clk),
    .srst(srst), .avs_read(avs_read), .avs_write(avs_write),
    .avs_waitrequest(avs_waitrequest), .kick_input(kick_input),
    .watchdog_disable_pin(watchdog_disable_pin),
    .timeout_config_pin_oe(timeout_config_pin_oe),
    .fault_output_n_o(fault_output_n_o),
    .fault_output_n_oe(fault_output_n_oe), .irq(irq));
`default_nettype wire
